// [core/srgs_pkg.sv]
// Shared constants and types for the serial port reset and generator sharing block.
//
// Summary of operation
// - Portion reset bit at 0 stops portion.
// - Inputs of a reset portion read known.
// - Output frame sync idles at polarity bit.
// - Output bit clocks follow generator clock.
// - Data output floats while transmitter reset.
// - Generator reset drives clock, sync low.
// - Frame sync inactive while own portion reset.
// - Emulator reset restores all register defaults.
// - Device reset resets all, floats output.
// - All reset bits read 0 after reset.
// - Portion reset bits written independently.
// - Internal receive sync uses both generators.
// - Internal clock, external sync: rate only.
// - External clock and sync: no generators.
// - Mode bit picks generator or copy sync.
// - Frame generator may stay reset if unused.
// - External clock, internal sync: copy only.
// - Internal transmit clock, external sync: rate only.
// - External transmit clock, sync: no generators.
// - Reset clears state machines, counters, flags.
`default_nettype none

package srgs_pkg;

	// ==========================================================
	// Register bus geometry and map.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_FRAME = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_TX_WORD = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_RX_WORD = 4'h5;

	// ==========================================================
	// Control register fields and reset value.
	localparam int CTL_RX_RUN = 0;
	localparam int CTL_TX_RUN = 1;
	localparam int CTL_GEN_RUN = 2;
	localparam int CTL_FRAME_RUN = 3;
	localparam int CTL_W = 4;
	localparam logic [CTL_W-1:0] CONTROL_RESET = 4'h0;

	// ==========================================================
	// Configuration register fields and reset value.
	localparam int CFG_RX_CLK_INT = 0;
	localparam int CFG_RX_SYNC_INT = 1;
	localparam int CFG_TX_CLK_INT = 2;
	localparam int CFG_TX_SYNC_INT = 3;
	localparam int CFG_RX_POL = 4;
	localparam int CFG_TX_POL = 5;
	localparam int CFG_MODE = 6;
	localparam int CFG_FLAGS_W = 7;
	localparam int CFG_DIV_LSB = 8;
	localparam int DIV_W = 8;
	localparam logic [CFG_FLAGS_W-1:0] CONFIG_FLAGS_RESET = 7'h00;
	localparam logic [DIV_W-1:0] DIVIDER_RESET = 8'h01;
	localparam int FRAME_W = 8;
	localparam logic [FRAME_W-1:0] FRAME_RESET = 8'h1F;

	// ==========================================================
	// Status register fields.
	localparam int ST_RX_READY = 0;
	localparam int ST_RX_OVERRUN = 1;
	localparam int ST_RX_SYNC_ERR = 2;
	localparam int ST_TX_READY = 3;
	localparam int ST_TX_UNDERFLOW = 4;
	localparam int ST_TX_SYNC_ERR = 5;
	localparam int ST_RX_USES_RATE = 6;
	localparam int ST_RX_USES_FRAME = 7;
	localparam int ST_TX_USES_RATE = 8;
	localparam int ST_TX_USES_FRAME = 9;
	localparam int ST_FRAME_NEEDED = 10;

	// ==========================================================
	// Synchroniser input lanes.
	localparam int LANE_RX_CLK = 0;
	localparam int LANE_RX_FS = 1;
	localparam int LANE_TX_CLK = 2;
	localparam int LANE_TX_FS = 3;
	localparam int LANE_DATA = 4;
	localparam int LANES = 5;

	// Word shifter states.
	typedef enum logic [1:0] {
		SRGS_IDLE = 2'b00,
		SRGS_ARMED = 2'b01,
		SRGS_SHIFT = 2'b10
	} srgs_state_t;

endpackage

`default_nettype wire

// [core/srgs_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses.
`default_nettype none

module srgs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	// ==========================================================
	// Per-lane chain.
	// The first stage feeds only the second; the filter looks at stages two and three.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gLane
			logic stage1_r;
			logic stage2_r;
			logic stage3_r;

			// Chain and filtered level, reset to a known low.
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					stage1_r <= 1'b0;
					stage2_r <= 1'b0;
					stage3_r <= 1'b0;
					level[i] <= 1'b0;
					rise[i] <= 1'b0;
					fall[i] <= 1'b0;
				end else begin
					stage1_r <= asyncIn[i];
					stage2_r <= stage1_r;
					stage3_r <= stage2_r;
					// A change counts only once two stages agree, which rejects one-cycle glitches.
					if (stage2_r == stage3_r && stage3_r != level[i]) begin
						level[i] <= stage3_r;
						rise[i] <= stage3_r;
						fall[i] <= ~stage3_r;
					end else begin
						rise[i] <= 1'b0;
						fall[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// [core/srgs_gen.sv]
// Shared sample rate generator and frame sync generator.
`default_nettype none

module srgs_gen #(
	parameter int DIV_BITS = 8,
	parameter int FRAME_BITS = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rateRun,
	input wire logic frameRun,
	input wire logic [DIV_BITS-1:0] divider,
	input wire logic [FRAME_BITS-1:0] framePeriod,
	output logic rateGeneratorClock,
	output logic clockRise,
	output logic clockFall,
	output logic generatedFrameSync
);

	logic [DIV_BITS-1:0] divCount_r;
	logic [FRAME_BITS-1:0] frameCount_r;

	initial begin
		if (DIV_BITS < 1 || FRAME_BITS < 1) begin
			$error("srgs_gen: widths must be at least one bit.");
		end
	end

	// ==========================================================
	// Clock divider: half period is divider+1 system cycles.
	// Only its own reset bit stops it, never a portion reset.
	always_ff @(posedge clk_sys) begin
		if (rst || !rateRun) begin
			divCount_r <= '0;
			rateGeneratorClock <= 1'b0;
			clockRise <= 1'b0;
			clockFall <= 1'b0;
		end else if (divCount_r == divider) begin
			divCount_r <= '0;
			rateGeneratorClock <= ~rateGeneratorClock;
			clockRise <= ~rateGeneratorClock;
			clockFall <= rateGeneratorClock;
		end else begin
			divCount_r <= divCount_r + 1'b1;
			clockRise <= 1'b0;
			clockFall <= 1'b0;
		end
	end

	// ==========================================================
	// Frame sync: one generator clock wide, every framePeriod+1 clocks.
	always_ff @(posedge clk_sys) begin
		if (rst || !rateRun || !frameRun) begin
			frameCount_r <= '0;
			generatedFrameSync <= 1'b0;
		end else if (clockRise) begin
			if (frameCount_r == framePeriod) begin
				frameCount_r <= '0;
				generatedFrameSync <= 1'b1;
			end else begin
				frameCount_r <= frameCount_r + 1'b1;
				generatedFrameSync <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// [core/srgs_port.sv]
// Serial port top: reset control, shared generator use, pins and word shifters.
//
// Local design decisions: the register offsets and the plain strobed port.
`default_nettype none

module srgs_port #(
	parameter int WORD_BITS = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic emulatorReset,
	input wire logic [srgs_pkg::ADDR_W-1:0] regAddr,
	input wire logic [srgs_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [srgs_pkg::DATA_W-1:0] regRdData,
	input wire logic receiveBitClockIn,
	output logic receiveBitClockOut,
	output logic receiveBitClockOe,
	input wire logic receiveFrameSyncIn,
	output logic receiveFrameSyncOut,
	output logic receiveFrameSyncOe,
	input wire logic transmitBitClockIn,
	output logic transmitBitClockOut,
	output logic transmitBitClockOe,
	input wire logic transmitFrameSyncIn,
	output logic transmitFrameSyncOut,
	output logic transmitFrameSyncOe,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOutOe
);

	localparam int CNT_W = $clog2(WORD_BITS + 1);
	localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_BITS - 1);

	initial begin
		if (WORD_BITS < 2 || WORD_BITS > srgs_pkg::DATA_W) begin
			$error("srgs_port: WORD_BITS must lie between 2 and the bus width.");
		end
	end

	// ==========================================================
	// Declarations.
	logic regReset;
	logic [srgs_pkg::CTL_W-1:0] control_r;
	logic [srgs_pkg::CFG_FLAGS_W-1:0] cfgFlags_r;
	logic [srgs_pkg::DIV_W-1:0] divider_r;
	logic [srgs_pkg::FRAME_W-1:0] framePeriod_r;
	logic rxRun, txRun, genRun, frameRun;
	logic rxClkInt, rxSyncInt, txClkInt, txSyncInt, rxPol, txPol, sourceMode;
	logic rxUsesRate, rxUsesFrame, txUsesRate, txUsesFrame, txCopyMode, frameNeeded;
	logic genClock, genRise, genFall, genSync;
	logic [srgs_pkg::LANES-1:0] pinLevel, pinRise, pinFall;
	logic rxRise, rxSync, rxSyncPrev_r, rxStart;
	logic txRise, txFall, txSync, txSyncPrev_r, txStart, txCopy;
	srgs_pkg::srgs_state_t rxState_r, txState_r;
	logic [CNT_W-1:0] rxCount_r, txCount_r;
	logic [WORD_BITS-1:0] rxShift_r, rxWord_r, txShift_r, holdWord_r;
	logic holdValid_r, copySync_r, dataBit_r;
	logic rxDone, rxErrEvt, txErrEvt, txUnderEvt;
	logic rxReady_r, rxOverrun_r, rxSyncErr_r, txUnder_r, txSyncErr_r;
	logic wrControl, wrConfig, wrFrame, wrStatus, wrTxWord, rdRxWord;
	logic [srgs_pkg::DATA_W-1:0] status;

	// Device reset and emulator reset both return every register to default.
	assign regReset = rst | emulatorReset;

	// ==========================================================
	// Register write decode.
	assign wrControl = regWr && regAddr == srgs_pkg::ADDR_CONTROL;
	assign wrConfig = regWr && regAddr == srgs_pkg::ADDR_CONFIG;
	assign wrFrame = regWr && regAddr == srgs_pkg::ADDR_FRAME;
	assign wrStatus = regWr && regAddr == srgs_pkg::ADDR_STATUS;
	assign wrTxWord = regWr && regAddr == srgs_pkg::ADDR_TX_WORD;
	assign rdRxWord = regRd && regAddr == srgs_pkg::ADDR_RX_WORD;

	// Reset bits: all four come out of reset at 0, so the port stays held.
	// Each bit is stored on its own, so one portion can change alone.
	always_ff @(posedge clk_sys) begin
		if (regReset) begin
			control_r <= srgs_pkg::CONTROL_RESET;
		end else if (wrControl) begin
			control_r <= regWrData[srgs_pkg::CTL_W-1:0];
		end
	end

	// Configuration, divider and frame period.
	always_ff @(posedge clk_sys) begin
		if (regReset) begin
			cfgFlags_r <= srgs_pkg::CONFIG_FLAGS_RESET;
			divider_r <= srgs_pkg::DIVIDER_RESET;
			framePeriod_r <= srgs_pkg::FRAME_RESET;
		end else begin
			if (wrConfig) begin
				cfgFlags_r <= regWrData[srgs_pkg::CFG_FLAGS_W-1:0];
				divider_r <= regWrData[srgs_pkg::CFG_DIV_LSB +: srgs_pkg::DIV_W];
			end
			if (wrFrame) begin
				framePeriod_r <= regWrData[srgs_pkg::FRAME_W-1:0];
			end
		end
	end

	assign rxRun = control_r[srgs_pkg::CTL_RX_RUN];
	assign txRun = control_r[srgs_pkg::CTL_TX_RUN];
	assign genRun = control_r[srgs_pkg::CTL_GEN_RUN];
	assign frameRun = control_r[srgs_pkg::CTL_FRAME_RUN];
	assign rxClkInt = cfgFlags_r[srgs_pkg::CFG_RX_CLK_INT];
	assign rxSyncInt = cfgFlags_r[srgs_pkg::CFG_RX_SYNC_INT];
	assign txClkInt = cfgFlags_r[srgs_pkg::CFG_TX_CLK_INT];
	assign txSyncInt = cfgFlags_r[srgs_pkg::CFG_TX_SYNC_INT];
	assign rxPol = cfgFlags_r[srgs_pkg::CFG_RX_POL];
	assign txPol = cfgFlags_r[srgs_pkg::CFG_TX_POL];
	assign sourceMode = cfgFlags_r[srgs_pkg::CFG_MODE];

	// ==========================================================
	// Shared generator use per clock and frame sync source.
	// An internal receive sync needs both generators whatever the clock source.
	assign rxUsesRate = rxClkInt | rxSyncInt;
	assign rxUsesFrame = rxSyncInt;
	// An external transmit clock cannot follow the frame generator, so it copies.
	assign txCopyMode = txSyncInt & (~txClkInt | ~sourceMode);
	assign txUsesRate = txClkInt;
	assign txUsesFrame = txClkInt & txSyncInt & sourceMode;
	// Reported so software knows the frame generator may be left in reset.
	assign frameNeeded = (rxRun & rxUsesFrame) | (txRun & txUsesFrame);

	// The rate generator sees only its own reset bit, the frame generator both bits; software keeps them running while used.
	srgs_gen #(
		.DIV_BITS(srgs_pkg::DIV_W),
		.FRAME_BITS(srgs_pkg::FRAME_W)
	) uGen (
		.clk_sys(clk_sys),
		.rst(regReset),
		.rateRun(genRun),
		.frameRun(frameRun),
		.divider(divider_r),
		.framePeriod(framePeriod_r),
		.rateGeneratorClock(genClock),
		.clockRise(genRise),
		.clockFall(genFall),
		.generatedFrameSync(genSync)
	);

	srgs_sync #(
		.WIDTH(srgs_pkg::LANES)
	) uSync (
		.clk_sys(clk_sys),
		.rst(regReset),
		.asyncIn({serialDataIn, transmitFrameSyncIn, transmitBitClockIn,
			receiveFrameSyncIn, receiveBitClockIn}),
		.level(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);

	// ==========================================================
	// Receiver.
	// A portion in reset sees no edges, so its inputs look still and known.
	assign rxRise = rxRun & (rxClkInt ? genRise : pinRise[srgs_pkg::LANE_RX_CLK]);
	assign rxSync = rxRun & (rxSyncInt ? genSync
		: (pinLevel[srgs_pkg::LANE_RX_FS] ^ rxPol));
	assign rxStart = rxRise & rxSync & ~rxSyncPrev_r;
	assign rxDone = rxRise && rxState_r == srgs_pkg::SRGS_SHIFT && rxCount_r == '0;
	assign rxErrEvt = rxStart && rxState_r == srgs_pkg::SRGS_SHIFT;

	// Receive shifter: frame sync on one rising edge, data on the next WORD_BITS.
	always_ff @(posedge clk_sys) begin
		if (regReset || !rxRun) begin
			rxState_r <= srgs_pkg::SRGS_IDLE;
			rxCount_r <= '0;
			rxShift_r <= '0;
			rxSyncPrev_r <= 1'b0;
		end else if (rxRise) begin
			rxSyncPrev_r <= rxSync;
			case (rxState_r)
				srgs_pkg::SRGS_IDLE: begin
					if (rxStart) begin
						rxState_r <= srgs_pkg::SRGS_SHIFT;
						rxCount_r <= LAST_BIT;
					end
				end
				srgs_pkg::SRGS_SHIFT: begin
					rxShift_r <= {rxShift_r[WORD_BITS-2:0], pinLevel[srgs_pkg::LANE_DATA]};
					if (rxCount_r == '0) begin
						rxState_r <= srgs_pkg::SRGS_IDLE;
					end else begin
						rxCount_r <= rxCount_r - 1'b1;
					end
				end
				default: begin
					rxState_r <= srgs_pkg::SRGS_IDLE;
				end
			endcase
		end
	end

	// Receive word and flags; a new event wins over a clear in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (regReset || !rxRun) begin
			rxWord_r <= '0;
			rxReady_r <= 1'b0;
			rxOverrun_r <= 1'b0;
			rxSyncErr_r <= 1'b0;
		end else begin
			if (rxDone) begin
				rxWord_r <= {rxShift_r[WORD_BITS-2:0], pinLevel[srgs_pkg::LANE_DATA]};
				rxReady_r <= 1'b1;
			end else if (rdRxWord) begin
				rxReady_r <= 1'b0;
			end
			if (rxDone && rxReady_r && !rdRxWord) begin
				rxOverrun_r <= 1'b1;
			end else if (wrStatus && regWrData[srgs_pkg::ST_RX_OVERRUN]) begin
				rxOverrun_r <= 1'b0;
			end
			if (rxErrEvt) begin
				rxSyncErr_r <= 1'b1;
			end else if (wrStatus && regWrData[srgs_pkg::ST_RX_SYNC_ERR]) begin
				rxSyncErr_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Transmitter.
	assign txRise = txRun & (txClkInt ? genRise : pinRise[srgs_pkg::LANE_TX_CLK]);
	assign txFall = txRun & (txClkInt ? genFall : pinFall[srgs_pkg::LANE_TX_CLK]);
	assign txSync = txRun & (txSyncInt ? genSync
		: (pinLevel[srgs_pkg::LANE_TX_FS] ^ txPol));
	assign txStart = txRise & ~txCopyMode & txSync & ~txSyncPrev_r;
	assign txErrEvt = txStart && txState_r != srgs_pkg::SRGS_IDLE;
	// Copy the holding word on a falling edge: at once in copy mode, else after a sync.
	assign txCopy = txFall && ((txState_r == srgs_pkg::SRGS_IDLE && txCopyMode && holdValid_r)
		|| txState_r == srgs_pkg::SRGS_ARMED);
	assign txUnderEvt = txCopy && !holdValid_r;

	// Transmit shifter, MSB first, one bit per falling edge.
	always_ff @(posedge clk_sys) begin
		if (regReset || !txRun) begin
			txState_r <= srgs_pkg::SRGS_IDLE;
			txCount_r <= '0;
			txShift_r <= '0;
			txSyncPrev_r <= 1'b0;
			copySync_r <= 1'b0;
			dataBit_r <= 1'b0;
		end else begin
			if (txRise) begin
				txSyncPrev_r <= txSync;
			end
			if (txCopy) begin
				// An empty holding word shifts out the old shift contents, which are all zero by then.
				txShift_r <= holdValid_r ? {holdWord_r[WORD_BITS-2:0], 1'b0}
					: {txShift_r[WORD_BITS-2:0], 1'b0};
				dataBit_r <= holdValid_r ? holdWord_r[WORD_BITS-1] : txShift_r[WORD_BITS-1];
				txCount_r <= LAST_BIT;
				txState_r <= srgs_pkg::SRGS_SHIFT;
				copySync_r <= txState_r == srgs_pkg::SRGS_IDLE;
			end else begin
				case (txState_r)
					srgs_pkg::SRGS_IDLE: begin
						if (txStart) begin
							txState_r <= srgs_pkg::SRGS_ARMED;
						end
					end
					// Armed waits for the copying falling edge; leaving early would lose the sync.
					srgs_pkg::SRGS_ARMED: begin
						txState_r <= srgs_pkg::SRGS_ARMED;
					end
					srgs_pkg::SRGS_SHIFT: begin
						if (txFall) begin
							copySync_r <= 1'b0;
							dataBit_r <= txShift_r[WORD_BITS-1];
							txShift_r <= {txShift_r[WORD_BITS-2:0], 1'b0};
							if (txCount_r == '0) begin
								txState_r <= srgs_pkg::SRGS_IDLE;
							end else begin
								txCount_r <= txCount_r - 1'b1;
							end
						end
					end
					default: begin
						txState_r <= srgs_pkg::SRGS_IDLE;
					end
				endcase
			end
		end
	end

	// Holding word: a write landing with a copy keeps the new word valid.
	always_ff @(posedge clk_sys) begin
		if (regReset) begin
			holdWord_r <= '0;
			holdValid_r <= 1'b0;
		end else if (wrTxWord) begin
			holdWord_r <= regWrData[WORD_BITS-1:0];
			holdValid_r <= 1'b1;
		end else if (txCopy) begin
			holdValid_r <= 1'b0;
		end
	end

	// Transmit flags; hardware events win over software clears.
	always_ff @(posedge clk_sys) begin
		if (regReset || !txRun) begin
			txUnder_r <= 1'b0;
			txSyncErr_r <= 1'b0;
		end else begin
			if (txUnderEvt) begin
				txUnder_r <= 1'b1;
			end else if (wrStatus && regWrData[srgs_pkg::ST_TX_UNDERFLOW]) begin
				txUnder_r <= 1'b0;
			end
			if (txErrEvt) begin
				txSyncErr_r <= 1'b1;
			end else if (wrStatus && regWrData[srgs_pkg::ST_TX_SYNC_ERR]) begin
				txSyncErr_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Pin drivers, all registered.
	// Default configuration makes every two-way pin an input and floats data out.
	always_ff @(posedge clk_sys) begin
		if (regReset) begin
			receiveBitClockOut <= 1'b0;
			receiveBitClockOe <= 1'b0;
			receiveFrameSyncOut <= 1'b0;
			receiveFrameSyncOe <= 1'b0;
			transmitBitClockOut <= 1'b0;
			transmitBitClockOe <= 1'b0;
			transmitFrameSyncOut <= 1'b0;
			transmitFrameSyncOe <= 1'b0;
			serialDataOut <= 1'b0;
			serialDataOutOe <= 1'b0;
		end else begin
			// Output bit clocks run from the generator even with the portion in reset.
			receiveBitClockOe <= rxClkInt;
			receiveBitClockOut <= genClock;
			transmitBitClockOe <= txClkInt;
			transmitBitClockOut <= genClock;
			// A reset portion holds its sync at the polarity bit, its inactive level.
			receiveFrameSyncOe <= rxSyncInt;
			receiveFrameSyncOut <= (rxRun & genSync) ^ rxPol;
			transmitFrameSyncOe <= txSyncInt;
			transmitFrameSyncOut <= (txRun & (txCopyMode ? copySync_r : genSync)) ^ txPol;
			serialDataOutOe <= txRun;
			serialDataOut <= txRun & dataBit_r;
		end
	end

	// ==========================================================
	// Register read port: data one cycle after the strobe, zero elsewhere.
	always_comb begin
		status = '0;
		status[srgs_pkg::ST_RX_READY] = rxReady_r;
		status[srgs_pkg::ST_RX_OVERRUN] = rxOverrun_r;
		status[srgs_pkg::ST_RX_SYNC_ERR] = rxSyncErr_r;
		status[srgs_pkg::ST_TX_READY] = txRun & ~holdValid_r;
		status[srgs_pkg::ST_TX_UNDERFLOW] = txUnder_r;
		status[srgs_pkg::ST_TX_SYNC_ERR] = txSyncErr_r;
		status[srgs_pkg::ST_RX_USES_RATE] = rxUsesRate;
		status[srgs_pkg::ST_RX_USES_FRAME] = rxUsesFrame;
		status[srgs_pkg::ST_TX_USES_RATE] = txUsesRate;
		status[srgs_pkg::ST_TX_USES_FRAME] = txUsesFrame;
		status[srgs_pkg::ST_FRAME_NEEDED] = frameNeeded;
	end

	always_ff @(posedge clk_sys) begin
		if (regReset) begin
			regRdData <= '0;
		end else if (regRd) begin
			case (regAddr)
				srgs_pkg::ADDR_CONTROL: begin
					regRdData <= srgs_pkg::DATA_W'(control_r);
				end
				srgs_pkg::ADDR_CONFIG: begin
					regRdData <= {divider_r, 1'b0, cfgFlags_r};
				end
				srgs_pkg::ADDR_FRAME: begin
					regRdData <= srgs_pkg::DATA_W'(framePeriod_r);
				end
				srgs_pkg::ADDR_STATUS: begin
					regRdData <= status;
				end
				srgs_pkg::ADDR_RX_WORD: begin
					regRdData <= srgs_pkg::DATA_W'(rxWord_r);
				end
				default: begin
					regRdData <= '0;
				end
			endcase
		end else begin
			regRdData <= '0;
		end
	end

endmodule

`default_nettype wire

// [dv/srgs_monitor.sv]
// Checker of reset and pin-state behaviour seen at the port's pins.
`default_nettype none
module srgs_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic emulatorReset,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic receiveBitClockOut,
	input wire logic receiveBitClockOe,
	input wire logic receiveFrameSyncOut,
	input wire logic receiveFrameSyncOe,
	input wire logic transmitBitClockOut,
	input wire logic transmitBitClockOe,
	input wire logic transmitFrameSyncOut,
	input wire logic transmitFrameSyncOe,
	input wire logic serialDataOut,
	input wire logic serialDataOutOe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ctl_r;
	logic [6:0] cfg_r;
	// ==========
	// Shadow of control and config, so pin rules are judged from the bus alone.
	always_ff @(posedge clk_sys) begin
		if (rst || emulatorReset) begin
			ctl_r <= 4'h0;
			cfg_r <= 7'h00;
		end else if (regWr && regAddr == 4'h0) begin
			ctl_r <= regWrData[3:0];
		end else if (regWr && regAddr == 4'h1) begin
			cfg_r <= regWrData[6:0];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence genHeld;
		!ctl_r[2] [*4];
	endsequence
	AST_EMU_FLOAT: assert property (emulatorReset |=>
		!serialDataOutOe && !receiveFrameSyncOe && !transmitFrameSyncOe) else $error("emu drive");
	AST_TX_FLOAT: assert property (!$past(ctl_r[1]) |-> !serialDataOutOe)
		else $error("data out driven");
	AST_DATA_QUIET: assert property (!serialDataOutOe |-> !serialDataOut)
		else $error("data out not low");
	AST_RX_SYNC_IDLE: assert property (receiveFrameSyncOe && !$past(ctl_r[0]) |->
		receiveFrameSyncOut == $past(cfg_r[4])) else $error("rx sync active");
	AST_TX_SYNC_IDLE: assert property (transmitFrameSyncOe && !$past(ctl_r[1]) |->
		transmitFrameSyncOut == $past(cfg_r[5])) else $error("tx sync active");
	AST_GEN_STOP: assert property (genHeld |-> !receiveBitClockOut && !transmitBitClockOut)
		else $error("clock runs");
	AST_CLK_SHARED: assert property (receiveBitClockOe && transmitBitClockOe |->
		receiveBitClockOut == transmitBitClockOut) else $error("clocks differ");
	AST_OE_CFG: assert property (!$past(emulatorReset) && !$past(rst) |->
		receiveFrameSyncOe == $past(cfg_r[1]) && transmitBitClockOe == $past(cfg_r[2])
		&& receiveBitClockOe == $past(cfg_r[0]) && transmitFrameSyncOe == $past(cfg_r[3]))
		else $error("pin direction");
endmodule
bind srgs_port srgs_monitor u_monitor (.*);
`default_nettype wire

// [dv/srgs_codec.sv]
// Far-side device model that sends one framed word on request.
`default_nettype none
module srgs_codec (
	input wire logic go,
	input wire logic [15:0] word,
	output logic bitClock,
	output logic frameSync,
	output logic dataLine
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bitClock = 1'b0;
		frameSync = 1'b0;
		dataLine = 1'b0;
	end
	// ==========
	// Clock runs only inside a frame; the line shows the inverse bit after it.
	always @(posedge go) begin
		#7;
		frameSync = 1'b1;
		for (int i = 16; i >= 0; i--) begin
			#160;
			bitClock = 1'b1;
			#160;
			bitClock = 1'b0;
			frameSync = 1'b0;
			if (i > 0) dataLine = word[i-1];
		end
		dataLine = ~dataLine;
	end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the reset and generator sharing block.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic emulatorReset = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic go = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [15:0] lfsr = 16'h386A;
	logic [15:0] regRdData, v;
	logic rxClk, rxClkOe, rxFs, rxFsOe, txClk, txClkOe, txFs, txFsOe, dOut, dOe;
	logic lkClk, lkSync, lkData;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int regM[3] = '{0, 'h100, 'h1F};
	int rxQ[$];
	// ==========
	// Clock, design and far side.
	always #20 clk_sys = ~clk_sys;
	srgs_port dut (.clk_sys(clk_sys), .rst(rst), .emulatorReset(emulatorReset),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .receiveBitClockIn(lkClk), .receiveBitClockOut(rxClk),
		.receiveBitClockOe(rxClkOe), .receiveFrameSyncIn(lkSync), .receiveFrameSyncOut(rxFs),
		.receiveFrameSyncOe(rxFsOe), .transmitBitClockIn(lkClk), .transmitBitClockOut(txClk),
		.transmitBitClockOe(txClkOe), .transmitFrameSyncIn(lkSync),
		.transmitFrameSyncOut(txFs), .transmitFrameSyncOe(txFsOe), .serialDataIn(lkData),
		.serialDataOut(dOut), .serialDataOutOe(dOe));
	srgs_codec partner (.go(go), .word(word), .bitClock(lkClk), .frameSync(lkSync),
		.dataLine(lkData));
	// Expected generator use for config flags c[3:0] and source mode c[4].
	// The frame-needed bit only counts portions that are out of reset.
	function automatic logic [15:0] usage(input int c);
		int rf, tf;
		rf = c >> 1 & 1;
		tf = c >> 2 & c >> 3 & c >> 4 & 1;
		return 16'((c & 1 | rf) << 6 | rf << 7 | (c >> 2 & 1) << 8 | tf << 9
			| (rf & regM[0] | tf & regM[0] >> 1) << 10);
	endfunction
	function automatic logic [15:0] nextLfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		if (a < 4'h3) regM[a] = int'(d) & (a == 0 ? 'hF : a == 1 ? 'hFF7F : 'hFF);
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		v = regRdData;
	endtask
	task automatic checkRegs();
		for (int a = 0; a < 3; a++) begin
			rd(4'(a));
			chk(v, 16'(regM[a]));
		end
	endtask
	// Half period of two cycles gives about fifty clock rises in 200 cycles.
	task automatic watch(input int txOn);
		int rises, bad, syncs;
		logic last;
		rises = 0;
		bad = 0;
		syncs = 0;
		last = txClk;
		repeat (200) begin
			@(posedge clk_sys);
			#1;
			rises += int'(txClk && !last);
			bad += int'(rxFs !== 1'b1);
			syncs += int'(txFs === 1'b1);
			last = txClk;
		end
		chk(16'(rises > 45 && rises < 55), 1);
		chk(16'(bad), 0);
		chk(16'(syncs > 0), 16'(txOn));
	endtask
	task automatic sendWord();
		lfsr = nextLfsr(lfsr);
		rxQ.push_back(int'(lfsr));
		@(posedge clk_sys);
		word <= lfsr;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (160) @(posedge clk_sys);
	endtask
	task automatic complete_run();
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		checkRegs();
		chk(16'(dOe), 0);
		for (int i = 0; i < 32; i++) begin
			wr(4'h1, 16'h0100 | 16'(i & 15) | 16'(i >> 4 << 6));
			rd(4'h3);
			chk(v & 16'h07C0, usage(i));
		end
		wr(4'h1, 16'h015F);
		wr(4'h2, 16'h0003);
		wr(4'h0, 16'h000C);
		watch(0);
		wr(4'h0, 16'h000E);
		watch(1);
		chk(16'(dOe), 1);
		rd(4'h3);
		chk(v & 16'h07C0, usage(31));
		wr(4'h0, 16'h000C);
		wr(4'h0, 16'h0000);
		repeat (8) @(posedge clk_sys);
		chk(16'({rxClk, txClk, dOe, rxFs}), 1);
		wr(4'h1, 16'h0100);
		wr(4'h0, 16'h0001);
		sendWord();
		rd(4'h3);
		chk(v & 16'h0007, 1);
		rd(4'h5);
		chk(v, 16'(rxQ.pop_front()));
		sendWord();
		wr(4'h0, 16'h0000);
		rd(4'h3);
		chk(v & 16'h0007, 0);
		sendWord();
		rd(4'h3);
		chk(v & 16'h0007, 0);
		wr(4'h1, 16'h0312);
		wr(4'h0, 16'h0003);
		emulatorReset <= 1'b1;
		@(posedge clk_sys);
		emulatorReset <= 1'b0;
		regM = '{0, 'h100, 'h1F};
		checkRegs();
		complete_run();
	end
endmodule
`default_nettype wire
